// ---- src/erdm_rx_desc_mgr.sv ----
// receive buffer descriptor manager with apb registers and memory master
// Functional notes
// - specific address matches in bits 26..23
// - type match bit 22, vlan bit 21
// - priority tag: vlan with zero id
// - vlan priority 19:17, cfi bit 16
// - end of frame flag bit 15
// - start of frame flag bit 14
// - offset or jumbo length in 13:12
// - frame length in bits 11:0
// - fetch descriptor when frame data starts
// - write data only after copy; reclaim
// - wrap bit or 1024th returns to start (here a spill fetch after the 1024th reads base plus 8192)
// - 11-bit counter plus base forms pointer
// - counter clears on wrap, rolls at 1024
// - set used bit; reclaim current only
// - used descriptor raises buffer-not-available
// - used descriptor mid frame drops frame
// - bus error or timeout is overrun
// - fcs stripping shortens length by four
// - 128-byte buffers, first shrinks by offset (here every buffer takes 32 words; the offset only goes into status bits 13:12)
// - broadcast and hash matches in 31..28
// - spill buffer status holds sof, offset
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module erdm_rx_desc_mgr
    import erdm_pkg::*;
#(
    parameter int TMO_CYC = BUS_TMO_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory master
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    // receive block
    input wire logic rx_start,
    input wire logic rx_copy,
    input wire logic rx_discard,
    input wire logic rx_valid,
    input wire logic [31:0] rx_data,
    input wire logic rx_fcs_word,
    output logic rx_ready,
    input wire logic rx_end,
    input wire logic rx_err,
    input wire logic [13:0] rx_len,
    // address filter results
    input wire logic rx_bcast,
    input wire logic rx_mhash,
    input wire logic rx_uhash,
    input wire logic rx_extm,
    input wire logic [3:0] rx_sa,
    input wire logic rx_type_match,
    input wire logic [15:0] rx_type_id,
    input wire logic [15:0] rx_vlan_tci,
    // events
    output logic buf_not_avail,
    output logic rx_overrun,
    output logic res_err_inc
);
    // =========================================================
    // storage
    erdm_state_t state_ff;
    logic rxen_ff, jumbo_ff, nofcs_ff;
    logic [1:0] off_ff;
    logic bna_st_ff, ovr_st_ff;
    logic [31:0] base_ff, rescnt_ff, prdata_ff;
    logic [10:0] cnt_ff;
    logic pready_ff, pslverr_ff;
    logic req_ff, we_ff;
    logic [31:0] addr_ff, wdata_ff, bufadr_ff;
    logic wrap_ff, sof_ff, copy_ff, end_ff, err_ff, rdy_ff, fin_ff;
    logic [5:0] wcnt_ff;
    logic [15:0] tmo_ff;
    logic bna_ff, ovr_ff, rse_ff;
    logic [31:0] match_ff;
    logic [13:0] len_ff;
    logic [31:0] qptr, stat_fin, stat_spill;
    logic [13:0] len_adj;
    logic apb_wr, bus_fail, bus_ok, vlan;
    // =========================================================
    // apb access decode
    assign apb_wr = psel && penable && pready_ff && pwrite;
    assign qptr = base_ff + {19'h0, cnt_ff, 2'b00};
    // one wait state, then ready with data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            unique case (paddr)
                ADDR_CTRL: prdata_ff[CTRL_RXEN] <= rxen_ff;
                ADDR_CFG: begin
                    prdata_ff[CFG_JUMBO] <= jumbo_ff;
                    prdata_ff[CFG_OFF_LO +: 2] <= off_ff;
                    prdata_ff[CFG_NOFCS] <= nofcs_ff;
                end
                ADDR_STAT: begin
                    prdata_ff[STAT_BNA] <= bna_st_ff;
                    prdata_ff[STAT_OVR] <= ovr_st_ff;
                end
                ADDR_QPTR: prdata_ff <= qptr;
                ADDR_RESCNT: prdata_ff <= rescnt_ff;
                default: pslverr_ff <= 1'b1;
            endcase
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end
    // control and configuration writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxen_ff <= 1'b0;
            jumbo_ff <= 1'b0;
            nofcs_ff <= 1'b0;
            off_ff <= 2'h0;
            base_ff <= 32'h0;
        end else if (apb_wr) begin
            if (paddr == ADDR_CTRL) rxen_ff <= pwdata[CTRL_RXEN];
            if (paddr == ADDR_CFG) begin
                jumbo_ff <= pwdata[CFG_JUMBO];
                off_ff <= pwdata[CFG_OFF_LO +: 2];
                nofcs_ff <= pwdata[CFG_NOFCS];
            end
            if (paddr == ADDR_QPTR) base_ff <= {pwdata[31:2], 2'b00};
        end
    end
    // sticky status, write one to clear, set wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bna_st_ff <= 1'b0;
            ovr_st_ff <= 1'b0;
        end else begin
            if (bna_ff) bna_st_ff <= 1'b1;
            else if (apb_wr && paddr == ADDR_STAT && pwdata[STAT_BNA])
                bna_st_ff <= 1'b0;
            if (ovr_ff) ovr_st_ff <= 1'b1;
            else if (apb_wr && paddr == ADDR_STAT && pwdata[STAT_OVR])
                ovr_st_ff <= 1'b0;
        end
    end
    // resource error statistics
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) rescnt_ff <= 32'h0;
        else if (rse_ff) rescnt_ff <= rescnt_ff + 32'h1;
    end
    // =========================================================
    // frame status assembly
    assign vlan = (rx_type_id == VLAN_TYPE);
    assign len_adj = nofcs_ff ? len_ff - FCS_BYTES : len_ff;
    always_comb begin
        stat_fin = match_ff;
        stat_fin[D1_EOF] = 1'b1;
        stat_fin[D1_SOF] = sof_ff;
        stat_fin[D1_OFF_LO +: 2] = jumbo_ff ? len_adj[13:12] :
            (sof_ff ? off_ff : 2'b00);
        stat_fin[11:0] = len_adj[11:0];
        stat_spill = 32'h0;
        stat_spill[D1_SOF] = sof_ff;
        stat_spill[D1_OFF_LO +: 2] = sof_ff ? off_ff : 2'b00;
    end
    // catch filter results when the frame ends
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            match_ff <= 32'h0;
            len_ff <= 14'h0;
        end else if (rx_end) begin
            match_ff <= 32'h0;
            match_ff[D1_BCAST -: 4] <= {rx_bcast, rx_mhash, rx_uhash,
                rx_extm};
            match_ff[D1_SA_HI -: 4] <= {rx_sa[0], rx_sa[1], rx_sa[2],
                rx_sa[3]};
            match_ff[D1_TYPE] <= rx_type_match;
            match_ff[D1_VLAN] <= vlan;
            match_ff[D1_PRIO] <= vlan && rx_vlan_tci[11:0] == 12'h0;
            match_ff[D1_PRI_LO +: 3] <= vlan ? rx_vlan_tci[15:13] : 3'h0;
            match_ff[D1_CFI] <= vlan && rx_vlan_tci[12];
            len_ff <= rx_len;
        end
    end
    // =========================================================
    // frame event latches
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            copy_ff <= 1'b0;
            end_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            copy_ff <= 1'b0;
            end_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            if (rx_copy) copy_ff <= 1'b1;
            if (rx_end) end_ff <= 1'b1;
            if (rx_err || rx_discard) err_ff <= 1'b1;
        end
    end
    // bus wait counter
    assign bus_ok = req_ff && mem_ack && !mem_err;
    assign bus_fail = req_ff && (mem_err ||
        (!mem_ack && tmo_ff == 16'(TMO_CYC)));
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) tmo_ff <= 16'h0;
        else if (req_ff && !mem_ack) tmo_ff <= tmo_ff + 16'h1;
        else tmo_ff <= 16'h0;
    end
    // =========================================================
    // buffer manager sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= 32'h0;
            wdata_ff <= 32'h0;
            bufadr_ff <= 32'h0;
            cnt_ff <= 11'h0;
            wrap_ff <= 1'b0;
            sof_ff <= 1'b0;
            fin_ff <= 1'b0;
            rdy_ff <= 1'b0;
            wcnt_ff <= 6'h0;
            bna_ff <= 1'b0;
            ovr_ff <= 1'b0;
            rse_ff <= 1'b0;
        end else begin
            bna_ff <= 1'b0;
            ovr_ff <= 1'b0;
            rse_ff <= 1'b0;
            if (bus_ok || bus_fail) req_ff <= 1'b0;
            if (apb_wr && paddr == ADDR_QPTR) cnt_ff <= 11'h0;
            unique case (state_ff)
                ST_IDLE: begin
                    sof_ff <= 1'b1;
                    if (rxen_ff && rx_start) begin
                        state_ff <= ST_FETCH;
                        req_ff <= 1'b1;
                        we_ff <= 1'b0;
                        addr_ff <= qptr;
                    end
                end
                ST_FETCH: begin
                    if (bus_fail) begin
                        ovr_ff <= 1'b1;
                        state_ff <= ST_DROP;
                    end else if (bus_ok && mem_rdata[D0_USED]) begin
                        bna_ff <= 1'b1;
                        rse_ff <= 1'b1;
                        state_ff <= ST_DROP;
                    end else if (bus_ok) begin
                        bufadr_ff <= {mem_rdata[31:2], 2'b00};
                        wrap_ff <= mem_rdata[D0_WRAP];
                        wcnt_ff <= 6'h0;
                        state_ff <= ST_WAITCP;
                    end
                end
                ST_WAITCP: begin
                    if (err_ff) state_ff <= ST_IDLE;
                    else if (copy_ff) begin
                        rdy_ff <= 1'b1;
                        state_ff <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (err_ff) begin
                        rdy_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else if (end_ff && !rx_valid) begin
                        rdy_ff <= 1'b0;
                        fin_ff <= 1'b1;
                        state_ff <= ST_STAT1;
                        req_ff <= 1'b1;
                        we_ff <= 1'b1;
                        addr_ff <= qptr + DESC_W1;
                        wdata_ff <= stat_fin;
                    end else if (rx_valid && rdy_ff) begin
                        if (!(rx_fcs_word && nofcs_ff)) begin
                            rdy_ff <= 1'b0;
                            state_ff <= ST_WRD;
                            req_ff <= 1'b1;
                            we_ff <= 1'b1;
                            addr_ff <= bufadr_ff + {24'h0, wcnt_ff, 2'b00};
                            wdata_ff <= rx_data;
                        end
                    end else if (rx_valid && wcnt_ff == BUF_WORDS) begin
                        fin_ff <= 1'b0;
                        state_ff <= ST_STAT1;
                        req_ff <= 1'b1;
                        we_ff <= 1'b1;
                        addr_ff <= qptr + DESC_W1;
                        wdata_ff <= stat_spill;
                    end
                end
                ST_WRD: begin
                    if (bus_fail) begin
                        ovr_ff <= 1'b1;
                        state_ff <= ST_DROP;
                    end else if (bus_ok) begin
                        wcnt_ff <= wcnt_ff + 6'h1;
                        rdy_ff <= (wcnt_ff + 6'h1) != BUF_WORDS;
                        state_ff <= ST_DATA;
                    end
                end
                ST_STAT1: begin
                    if (bus_fail) begin
                        ovr_ff <= 1'b1;
                        state_ff <= ST_DROP;
                    end else if (bus_ok) begin
                        state_ff <= ST_STAT0;
                        req_ff <= 1'b1;
                        addr_ff <= qptr;
                        wdata_ff <= {bufadr_ff[31:2], wrap_ff, 1'b1};
                    end
                end
                ST_STAT0: begin
                    if (bus_fail) begin
                        ovr_ff <= 1'b1;
                        state_ff <= ST_DROP;
                    end else if (bus_ok) begin
                        cnt_ff <= wrap_ff ? 11'h0 : cnt_ff + DESC_STEP;
                        sof_ff <= 1'b0;
                        if (fin_ff) state_ff <= ST_IDLE;
                        else begin
                            state_ff <= ST_FETCH;
                            req_ff <= 1'b1;
                            we_ff <= 1'b0;
                            addr_ff <= wrap_ff ? base_ff :
                                qptr + {19'h0, DESC_STEP, 2'b00};
                        end
                    end
                end
                ST_DROP: begin
                    if (end_ff || err_ff) state_ff <= ST_IDLE;
                end
            endcase
        end
    end
    // =========================================================
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_req = req_ff;
    assign mem_write = we_ff;
    assign mem_addr = addr_ff;
    assign mem_wdata = wdata_ff;
    assign rx_ready = rdy_ff;
    assign buf_not_avail = bna_ff;
    assign rx_overrun = ovr_ff;
    assign res_err_inc = rse_ff;
    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_fetch_used;
        state_ff == ST_FETCH && bus_ok && mem_rdata[D0_USED];
    endsequence
    property p_used_set;
        state_ff == ST_STAT0 && req_ff |-> mem_wdata[D0_USED];
    endproperty
    a_used_set: assert property (p_used_set)
        else $error("used bit missing");
    property p_bna;
        s_fetch_used |=> buf_not_avail ##1 !buf_not_avail;
    endproperty
    a_bna: assert property (p_bna)
        else $error("buffer not available not flagged");
    property p_drop;
        s_fetch_used |=> res_err_inc && state_ff == ST_DROP;
    endproperty
    a_drop: assert property (p_drop)
        else $error("used descriptor frame not dropped");
    property p_ovr;
        req_ff && mem_err |=> rx_overrun && !mem_req;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("bus error without overrun");
    property p_wrap;
        state_ff == ST_STAT0 && bus_ok && wrap_ff |=> cnt_ff == 11'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter not cleared on wrap");
    property p_prio;
        state_ff == ST_STAT1 && req_ff && mem_wdata[D1_PRIO]
            |-> mem_wdata[D1_VLAN];
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority tag without vlan");
    property p_spill;
        state_ff == ST_STAT1 && req_ff && !mem_wdata[D1_EOF]
            |-> mem_wdata[31:16] == 16'h0 && mem_wdata[11:0] == 12'h0;
    endproperty
    a_spill: assert property (p_spill)
        else $error("spill status not cleared");
    property p_copy;
        state_ff == ST_WRD |-> copy_ff && mem_write;
    endproperty
    a_copy: assert property (p_copy)
        else $error("data written before copy");
    property p_rsr_cnt;
        res_err_inc |=> rescnt_ff == $past(rescnt_ff) + 32'h1;
    endproperty
    a_rsr_cnt: assert property (p_rsr_cnt)
        else $error("resource counter not incremented");
endmodule : erdm_rx_desc_mgr

// ---- src/erdm_pkg.sv ----
// constants for the ethernet receive descriptor manager
package erdm_pkg;
    // =========================================================
    // register map (byte offsets)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_QPTR = 8'h0c;
    localparam logic [7:0] ADDR_RESCNT = 8'h10;
    // =========================================================
    // register fields
    localparam int CTRL_RXEN = 2;
    localparam int CFG_JUMBO = 3;
    localparam int CFG_OFF_LO = 14;
    localparam int CFG_NOFCS = 17;
    localparam int STAT_BNA = 0;
    localparam int STAT_OVR = 2;
    // =========================================================
    // descriptor word 0 and word 1 fields
    localparam int D0_USED = 0;
    localparam int D0_WRAP = 1;
    localparam int D1_BCAST = 31;
    localparam int D1_SA_HI = 26;
    localparam int D1_TYPE = 22;
    localparam int D1_VLAN = 21;
    localparam int D1_PRIO = 20;
    localparam int D1_PRI_LO = 17;
    localparam int D1_CFI = 16;
    localparam int D1_EOF = 15;
    localparam int D1_SOF = 14;
    localparam int D1_OFF_LO = 12;
    localparam logic [15:0] VLAN_TYPE = 16'h8100;
    localparam logic [13:0] FCS_BYTES = 14'h0004;
    // =========================================================
    // buffer geometry and list walking
    localparam logic [5:0] BUF_WORDS = 6'h20;
    localparam logic [10:0] DESC_STEP = 11'h002;
    localparam logic [31:0] DESC_W1 = 32'h0000_0004;
    // =========================================================
    // bus wait limit
    localparam int CLK_NS = 10;
    localparam int BUS_TMO_NS = 8915;
    localparam int BUS_TMO_CYC = BUS_TMO_NS / CLK_NS;
    // =========================================================
    // buffer manager states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_WAITCP = 3'b010,
        ST_DATA = 3'b011,
        ST_WRD = 3'b100,
        ST_STAT1 = 3'b101,
        ST_STAT0 = 3'b110,
        ST_DROP = 3'b111
    } erdm_state_t;
endpackage : erdm_pkg

// ---- testbench/erdm_mem_model.sv ----
// behavioural system memory behind the descriptor manager's master
`timescale 1ns/10ps
module erdm_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // memory port
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata,
    // answer control from the bench
    input wire logic [1:0] dly,
    input wire logic fail
);
    logic [31:0] mem [0:255];
    logic [1:0] wait_ff;
    logic gap_ff;
    logic busy;
    logic fire;
    // a request is open, not in or just after an answer
    assign busy = mem_req && !gap_ff && !mem_ack && !mem_err;
    assign fire = busy && wait_ff == dly;
    // answer after dly idle cycles; released data toggles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_ff <= 2'h0;
            gap_ff <= 1'b0;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            gap_ff <= mem_ack | mem_err;
            mem_ack <= fire && !fail;
            mem_err <= fire && fail;
            wait_ff <= (busy && !fire) ? wait_ff + 2'h1 : 2'h0;
            mem_rdata <= fire ? mem[mem_addr[9:2]] : ~mem_rdata;
        end
    end
    // array: bench preloads it, writes land on ack
    always @(posedge clk_sys) begin
        if (fire && !fail && mem_write) begin
            mem[mem_addr[9:2]] <= mem_wdata;
        end
    end
endmodule : erdm_mem_model

// ---- testbench/erdm_rx_desc_mgr_test.sv ----
// random and corner-case bench for the receive descriptor manager
`timescale 1ns/10ps
module erdm_rx_desc_mgr_test
    import erdm_pkg::*;
;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, fail;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rx_data, q;
    logic mem_req, mem_write, mem_ack, mem_err, rx_start, rx_copy, rx_err;
    logic rx_discard, rx_valid, rx_fcs_word, rx_ready, rx_end, rx_bcast;
    logic rx_mhash, rx_uhash, rx_extm, rx_type_match, buf_not_avail;
    logic rx_overrun, res_err_inc, nofcs, jumbo;
    logic [13:0] rx_len;
    logic [3:0] rx_sa;
    logic [15:0] rx_type_id, rx_vlan_tci;
    logic [1:0] dly, off;
    logic [31:0] wd [0:63];
    int seed, cur, nw, err_total, samples_checked, n_bna, n_ovr, n_res;
    erdm_rx_desc_mgr #(.TMO_CYC(20)) erdm_rx_desc_mgr_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
        .rx_start(rx_start), .rx_copy(rx_copy), .rx_discard(rx_discard),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_fcs_word(rx_fcs_word),
        .rx_ready(rx_ready), .rx_end(rx_end), .rx_err(rx_err),
        .rx_len(rx_len), .rx_bcast(rx_bcast), .rx_mhash(rx_mhash),
        .rx_uhash(rx_uhash), .rx_extm(rx_extm), .rx_sa(rx_sa),
        .rx_type_match(rx_type_match), .rx_type_id(rx_type_id),
        .rx_vlan_tci(rx_vlan_tci), .buf_not_avail(buf_not_avail),
        .rx_overrun(rx_overrun), .res_err_inc(res_err_inc));
    erdm_mem_model erdm_mem_model_inst (.clk_sys(clk_sys), .rst(rst),
        .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
        .mem_rdata(mem_rdata), .dly(dly), .fail(fail));
    // =========================================================
    // clock and event counters
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        n_bna <= n_bna + int'(buf_not_avail === 1'b1);
        n_ovr <= n_ovr + int'(rx_overrun === 1'b1);
        n_res <= n_res + int'(res_err_inc === 1'b1);
    end
    // =========================================================
    // helpers
    function automatic logic [31:0] mw(input int i);
        return erdm_mem_model_inst.mem[i];
    endfunction : mw
    function automatic logic [31:0] dsc0(input int d);
        return 32'(32'h200 + 128 * d) | (d == 2 ? 32'h2 : 32'h0);
    endfunction : dsc0
    function automatic logic [31:0] exp_st(input logic sof, input logic eof);
        logic [13:0] l;
        logic v;
        l = rx_len - (nofcs ? FCS_BYTES : 14'h0);
        v = rx_type_id == VLAN_TYPE;
        exp_st = 32'h0;
        exp_st[14] = sof;
        exp_st[13:12] = jumbo ? l[13:12] : (sof ? off : 2'h0);
        if (eof) begin
            exp_st[31:28] = {rx_bcast, rx_mhash, rx_uhash, rx_extm};
            exp_st[26:23] = {rx_sa[0], rx_sa[1], rx_sa[2], rx_sa[3]};
            exp_st[22:21] = {rx_type_match, v};
            exp_st[20] = v && rx_vlan_tci[11:0] == 12'h0;
            exp_st[19:16] = v ? rx_vlan_tci[15:12] : 4'h0;
            exp_st[15] = 1'b1;
            exp_st[11:0] = l[11:0];
        end
    endfunction : exp_st
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk32
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = pslverr === 1'b1 ? 32'hbad0 : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic init_list;
        for (int d = 0; d < 3; d++) begin
            erdm_mem_model_inst.mem[64 + 2 * d] = dsc0(d);
            erdm_mem_model_inst.mem[65 + 2 * d] = 32'h5a5a_5a5a;
        end
    endtask : init_list
    // one frame on the receive side; a stalled word ends it early
    task automatic frame(input int n_w);
        int n;
        rx_start <= 1'b1;
        @(posedge clk_sys);
        rx_start <= 1'b0;
        rx_copy <= 1'b1;
        @(posedge clk_sys);
        rx_copy <= 1'b0;
        for (int i = 0; i < n_w; i++) begin
            rx_valid <= 1'b1;
            rx_data <= wd[i];
            rx_fcs_word <= nofcs && i == n_w - 1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (rx_ready !== 1'b1 && n < 60);
            if (n >= 60) break;
        end
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        @(posedge clk_sys);
        rx_end <= 1'b0;
    endtask : frame
    task automatic run(input int n_w);
        int ns, nb, dk, n;
        logic [31:0] r;
        init_list();
        r = $random(seed);
        for (int i = 0; i < n_w; i++) wd[i] = $random(seed);
        rx_len <= 14'(n_w * 4);
        {rx_bcast, rx_mhash, rx_uhash, rx_extm, rx_sa} <= r[7:0];
        rx_type_match <= r[8];
        rx_type_id <= r[9] ? VLAN_TYPE : r[31:16];
        rx_vlan_tci <= r[10] ? {r[15:12], 12'h0} : r[31:16];
        frame(n_w);
        ns = n_w - int'(nofcs);
        nb = (n_w + 31) / 32;
        n = 0;
        while (mw(64 + 2 * ((cur + nb - 1) % 3)) % 2 !== 1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        for (int j = 0; j < ns; j++) begin
            dk = (cur + j / 32) % 3;
            chk32(mw(128 + 32 * dk + j % 32), wd[j]);
        end
        for (int k = 0; k < nb; k++) begin
            dk = (cur + k) % 3;
            r = (k == nb - 1 && rx_type_id !== VLAN_TYPE) ? 32'hfff0ffff : '1;
            chk32(mw(65 + 2 * dk) & r, exp_st(k == 0, k == nb - 1));
            chk32(mw(64 + 2 * dk), dsc0(dk) | 32'h1);
        end
        cur = (cur + nb) % 3;
        apb(1'b0, ADDR_QPTR, 32'h0, r);
        chk32(r, 32'h100 + 32'(8 * cur));
    endtask : run
    task automatic end_sim;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // =========================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fail, dly} = '0;
        {rx_start, rx_copy, rx_discard, rx_valid, rx_data, rx_err} = '0;
        {rx_fcs_word, rx_end, rx_len, rx_sa, rx_type_id, rx_vlan_tci} = '0;
        {rx_bcast, rx_mhash, rx_uhash, rx_extm, rx_type_match} = '0;
        {err_total, samples_checked, n_bna, n_ovr, n_res, cur} = '0;
        seed = 32'h5d6e;
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk32({29'h0, mem_req, rx_ready, pready}, 32'h0);
        apb(1'b1, ADDR_QPTR, 32'h103, q);
        apb(1'b0, ADDR_QPTR, 32'h0, q);
        chk32(q, 32'h100);
        apb(1'b0, 8'h20, 32'h0, q);
        chk32(q, 32'hbad0);
        apb(1'b1, ADDR_CTRL, 32'h4, q);
        for (int f = 0; f < 7; f++) begin
            q = $random(seed);
            nw = f == 1 || f == 2 ? 33 : 2 + int'(q[20:16]) % 31;
            off = q[1:0];
            jumbo = q[2] && nw < 33;
            nofcs = f == 1 ? 1'b0 : (f == 2 ? 1'b1 : q[3]);
            dly <= q[5:4];
            apb(1'b1, ADDR_CFG, 32'({nofcs, 1'b0, off, 10'h0, jumbo, 3'h0}), q);
            run(nw);
        end
        init_list();
        erdm_mem_model_inst.mem[64 + 2 * cur] = dsc0(cur) | 32'h1;
        frame(4);
        repeat (20) @(posedge clk_sys);
        chk32(32'(n_bna != 0), 32'h1);
        chk32(32'(n_res), 32'h1);
        apb(1'b0, ADDR_RESCNT, 32'h0, q);
        chk32(q, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0, q);
        chk32(q & 32'h5, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h5, q);
        init_list();
        fail <= 1'b1;
        frame(4);
        repeat (40) @(posedge clk_sys);
        fail <= 1'b0;
        chk32(32'(n_ovr != 0), 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0, q);
        chk32(q & 32'h5, 32'h4);
        rx_discard <= 1'b1;
        frame(4);
        rx_discard <= 1'b0;
        chk32(mw(64 + 2 * cur), dsc0(cur));
        run(3);
        end_sim();
    end
    // hang guard, far beyond the expected run length
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
endmodule : erdm_rx_desc_mgr_test
